//--- hdl/serial_port_config_apply.sv
// Serial port with pending and active settings, reached over APB.
// Assumes an APB master on core_clk; rxd is synchronous to core_clk.
//
// Summary of operation
// - Bit rate is one of 300, 600, 1200, 2400, 4800 or 9600 bits per second.
// - After reset the bit rate setting is 9600 until changed and applied.
// - Data length accepts only 7 or 8; any other written value is refused.
// - After reset the data length is 8 bits.
// - Parity is N for none, E for even or O for odd.
// - Stop bit count accepts only 1 or 2; any other written value is refused.
// - After reset one stop bit is used.
// - Setting writes stay pending and leave the line framing alone until applied.
// - Apply copies every pending setting to the active set and restarts tx and rx.
// - There is no flow control and the flow query always answers none.
// - Every setting reads back: parity as N, E or O, length 7 or 8, a listed rate.
// - The stop bit count reads back as 1 or 2.
`timescale 1ns/1ps
module serial_port_config_apply
	import serial_cfg_pkg::*;
#(
	parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
	input  wire logic   core_clk,
	input  wire logic   sys_rst,
	input  apb_req_t    apb_req,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	input  wire logic   rxd,
	output logic        txd,
	output serial_cfg_t active_cfg
);
	typedef struct packed {
		serial_cfg_t pend;
		serial_cfg_t act;
		logic        restart;
		logic [31:0] rdata;
		logic [7:0]  rx_data;
		logic        rx_valid;
		logic        perr;
		logic        ferr;
		logic        ovr;
		logic        rej;
		logic        tx_go;
		logic [7:0]  tx_byte;
	} top_state_t;

	localparam top_state_t TOP_RESET = '{pend: CFG_RESET, act: CFG_RESET, restart: 1'h0,
		rdata: 32'h0, rx_data: 8'h00, rx_valid: 1'h0, perr: 1'h0, ferr: 1'h0, ovr: 1'h0,
		rej: 1'h0, tx_go: 1'h0, tx_byte: 8'h00};

	top_state_t       st_r;
	top_state_t       st_nxt;
	logic             setup;
	logic             access;
	logic             mapped;
	logic             bad_val;
	logic             wr_ok;
	logic             rd_done;
	logic [3:0]       rate_dec;
	logic [2:0]       par_dec;
	logic [31:0]      rd_word;
	logic [31:0]      status;
	logic             tx_busy;
	logic [CNT_W-1:0] bit_cycles;
	rx_evt_t          rx_evt;

	////////////////////////////////////////////////////////////////////////////
	// Each division has constant operands, so it folds to a table of counts
	function automatic logic [CNT_W-1:0] cycles_for(rate_t r);
		case (r)
			RATE_300:  return CNT_W'(CLK_HZ / BPS_300);
			RATE_600:  return CNT_W'(CLK_HZ / BPS_600);
			RATE_1200: return CNT_W'(CLK_HZ / BPS_1200);
			RATE_2400: return CNT_W'(CLK_HZ / BPS_2400);
			RATE_4800: return CNT_W'(CLK_HZ / BPS_4800);
			default:   return CNT_W'(CLK_HZ / BPS_9600);
		endcase
	endfunction

	function automatic logic [31:0] rate_word(rate_t r);
		case (r)
			RATE_300:  return BPS_300;
			RATE_600:  return BPS_600;
			RATE_1200: return BPS_1200;
			RATE_2400: return BPS_2400;
			RATE_4800: return BPS_4800;
			default:   return BPS_9600;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// APB decode; the slave never inserts wait states
	assign setup    = apb_req.psel && !apb_req.penable;
	assign access   = apb_req.psel && apb_req.penable;
	assign rate_dec = rate_code(apb_req.pwdata);
	assign par_dec  = par_code(apb_req.pwdata);
	assign pready   = 1'h1;
	assign pslverr  = access && (!mapped || bad_val);
	assign wr_ok    = access && apb_req.pwrite && mapped && !bad_val;
	assign rd_done  = access && !apb_req.pwrite;

	always_comb begin
		mapped = 1'h1;
		bad_val = 1'h0;
		unique case (apb_req.paddr)
			OFS_RATE: bad_val = apb_req.pwrite && !rate_dec[3];
			OFS_LEN: bad_val = apb_req.pwrite && apb_req.pwdata != LEN_7_W
				&& apb_req.pwdata != LEN_8_W;
			OFS_PAR: bad_val = apb_req.pwrite && !par_dec[2];
			OFS_STOP: bad_val = apb_req.pwrite && apb_req.pwdata != STOP_1_W
				&& apb_req.pwdata != STOP_2_W;
			// A byte written while the transmitter is busy would be lost
			OFS_TXD: bad_val = apb_req.pwrite && (tx_busy || st_r.tx_go);
			OFS_APPLY, OFS_FLOW, OFS_STAT, OFS_RXD, OFS_ACT: bad_val = 1'h0;
			default: mapped = 1'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data is captured in the setup cycle so prdata comes from a flop
	always_comb begin
		status = 32'h0;
		status[ST_TX_BUSY] = tx_busy || st_r.tx_go;
		status[ST_RX_VALID] = st_r.rx_valid;
		status[ST_PAR_ERR] = st_r.perr;
		status[ST_FRM_ERR] = st_r.ferr;
		status[ST_OVERRUN] = st_r.ovr;
		status[ST_REJECT] = st_r.rej;
		rd_word = 32'h0;
		unique case (apb_req.paddr)
			OFS_RATE: rd_word = rate_word(st_r.pend.rate);
			OFS_LEN: rd_word = st_r.pend.len8 ? LEN_8_W : LEN_7_W;
			OFS_PAR: rd_word = (st_r.pend.par == PAR_EVEN) ? CHAR_E_W :
				(st_r.pend.par == PAR_ODD) ? CHAR_O_W : CHAR_N_W;
			OFS_STOP: rd_word = st_r.pend.stop2 ? STOP_2_W : STOP_1_W;
			OFS_FLOW: rd_word = FLOW_NONE_W;
			OFS_STAT: rd_word = status;
			OFS_RXD: rd_word = {24'h0, st_r.rx_data};
			OFS_ACT: rd_word = {25'h0, st_r.act};
			default: rd_word = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.restart = 1'h0;
		st_nxt.tx_go = 1'h0;
		if (setup) begin
			st_nxt.rdata = rd_word;
		end
		if (wr_ok) begin
			unique case (apb_req.paddr)
				OFS_RATE: st_nxt.pend.rate = rate_t'(rate_dec[2:0]);
				OFS_LEN: st_nxt.pend.len8 = (apb_req.pwdata == LEN_8_W);
				OFS_PAR: st_nxt.pend.par = parity_t'(par_dec[1:0]);
				OFS_STOP: st_nxt.pend.stop2 = (apb_req.pwdata == STOP_2_W);
				OFS_APPLY: begin
					st_nxt.act = st_r.pend;
					st_nxt.restart = 1'h1;
				end
				OFS_TXD: begin
					st_nxt.tx_go = 1'h1;
					st_nxt.tx_byte = apb_req.pwdata[7:0];
				end
				OFS_STAT: begin
					if (apb_req.pwdata[ST_PAR_ERR]) st_nxt.perr = 1'h0;
					if (apb_req.pwdata[ST_FRM_ERR]) st_nxt.ferr = 1'h0;
					if (apb_req.pwdata[ST_OVERRUN]) st_nxt.ovr = 1'h0;
					if (apb_req.pwdata[ST_REJECT]) st_nxt.rej = 1'h0;
				end
				default: st_nxt.tx_go = 1'h0;
			endcase
		end
		if (rd_done && apb_req.paddr == OFS_RXD) begin
			st_nxt.rx_valid = 1'h0;
		end
		// Hardware sets come after the clears so a same-cycle event is kept
		if (access && apb_req.pwrite && bad_val) begin
			st_nxt.rej = 1'h1;
		end
		if (rx_evt.valid) begin
			st_nxt.rx_data = rx_evt.data;
			st_nxt.rx_valid = 1'h1;
			st_nxt.perr = st_r.perr || rx_evt.perr;
			st_nxt.ferr = st_r.ferr || rx_evt.ferr;
			if (st_r.rx_valid && !(rd_done && apb_req.paddr == OFS_RXD)) begin
				st_nxt.ovr = 1'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= TOP_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata     = st_r.rdata;
	assign active_cfg = st_r.act;

	assign bit_cycles = cycles_for(st_r.act.rate);

	////////////////////////////////////////////////////////////////////////////
	serial_tx u_tx (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.restart    (st_r.restart),
		.cfg        (st_r.act),
		.bit_cycles (bit_cycles),
		.start      (st_r.tx_go),
		.data       (st_r.tx_byte),
		.busy       (tx_busy),
		.txd        (txd)
	);

	serial_rx u_rx (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.restart    (st_r.restart),
		.cfg        (st_r.act),
		.bit_cycles (bit_cycles),
		.rxd        (rxd),
		.evt        (rx_evt)
	);

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	chk_rate_write_back: assert property (
		wr_ok && apb_req.paddr == OFS_RATE |=> rate_word(st_r.pend.rate) == $past(apb_req.pwdata))
		else $error("legal rate write not stored");
	chk_reset_rate: assert property (disable iff (1'h0)
		$fell(sys_rst) |-> st_r.act.rate == RATE_9600 && st_r.pend.rate == RATE_9600)
		else $error("rate not 9600 after reset");
	chk_len_reject: assert property (
		access && apb_req.pwrite && apb_req.paddr == OFS_LEN && apb_req.pwdata != LEN_7_W
		&& apb_req.pwdata != LEN_8_W |-> pslverr ##1 $stable(st_r.pend.len8))
		else $error("illegal length not refused");
	chk_reset_len: assert property (disable iff (1'h0)
		$fell(sys_rst) |-> st_r.act.len8 && st_r.pend.len8)
		else $error("length not 8 after reset");
	chk_parity_even: assert property (
		wr_ok && apb_req.paddr == OFS_PAR && apb_req.pwdata == CHAR_E_W
		|=> st_r.pend.par == PAR_EVEN)
		else $error("even parity code not taken");
	chk_stop_reject: assert property (
		access && apb_req.pwrite && apb_req.paddr == OFS_STOP && apb_req.pwdata != STOP_1_W
		&& apb_req.pwdata != STOP_2_W |-> pslverr && st_r.rej == $past(st_r.rej) ##1 st_r.rej)
		else $error("illegal stop count not refused");
	chk_reset_stop: assert property (disable iff (1'h0)
		$fell(sys_rst) |-> !st_r.act.stop2 && !st_r.pend.stop2)
		else $error("stop count not 1 after reset");
	chk_pending_hold: assert property (
		!(wr_ok && apb_req.paddr == OFS_APPLY) |=> $stable(st_r.act) && !st_r.restart)
		else $error("active framing changed without apply");
	chk_apply_copy: assert property (
		wr_ok && apb_req.paddr == OFS_APPLY |=> st_r.act == $past(st_r.pend) && st_r.restart
		##1 !tx_busy)
		else $error("apply did not copy and restart");
	chk_flow_none: assert property (
		setup && apb_req.paddr == OFS_FLOW |=> prdata == FLOW_NONE_W)
		else $error("flow query not none");
	chk_len_readback: assert property (
		setup && apb_req.paddr == OFS_LEN |=> prdata == LEN_7_W || prdata == LEN_8_W)
		else $error("length reads back out of range");
	chk_stop_readback: assert property (
		setup && apb_req.paddr == OFS_STOP && st_r.pend.stop2 |=> prdata == STOP_2_W)
		else $error("stop count readback wrong");
	chk_divider_pick: assert property (
		st_r.act.rate == RATE_9600 |-> bit_cycles == CNT_W'(CLK_HZ / BPS_9600))
		else $error("divider does not follow active rate");
	chk_parity_odd: assert property (
		wr_ok && apb_req.paddr == OFS_PAR && apb_req.pwdata == CHAR_O_W
		|=> st_r.pend.par == PAR_ODD)
		else $error("odd parity code not taken");
	chk_flow_no_error: assert property (
		access && apb_req.paddr == OFS_FLOW |-> !pslverr)
		else $error("flow register access refused");
	chk_parity_readback: assert property (
		setup && apb_req.paddr == OFS_PAR
		|=> prdata == CHAR_N_W || prdata == CHAR_E_W || prdata == CHAR_O_W)
		else $error("parity reads back out of range");
	chk_restart_line_idle: assert property (
		st_r.restart |=> txd && !tx_busy)
		else $error("restart left the transmitter running");

endmodule

//--- hdl/serial_rx.sv
// Serial receiver: samples each bit at its centre and reports one event per frame.
// Assumes rxd is synchronous to core_clk; cfg changes only with a restart pulse.
`timescale 1ns/1ps
module serial_rx
	import serial_cfg_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             restart,
	input  serial_cfg_t           cfg,
	input  wire logic [CNT_W-1:0] bit_cycles,
	input  wire logic             rxd,
	output rx_evt_t               evt
);
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} rx_st_t;

	typedef struct packed {
		rx_st_t           st;
		logic [CNT_W-1:0] cnt;
		logic [3:0]       nbit;
		logic [7:0]       sh;
		logic             perr;
		rx_evt_t          evt;
	} rx_state_t;

	localparam rx_state_t RX_RESET = '{st: RX_IDLE, cnt: '0, nbit: 4'h0, sh: 8'h00,
		perr: 1'h0, evt: '0};

	rx_state_t        st_r;
	rx_state_t        st_nxt;
	logic             tick;
	logic [CNT_W-1:0] reload;
	logic [7:0]       byte_in;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.evt.valid = 1'h0;
		tick = (st_r.cnt == '0);
		reload = bit_cycles - 1'h1;
		// Seven-bit frames shift in one place short
		byte_in = cfg.len8 ? st_r.sh : {1'h0, st_r.sh[7:1]};
		if (st_r.st != RX_IDLE && !tick) begin
			st_nxt.cnt = st_r.cnt - 1'h1;
		end
		unique case (st_r.st)
			RX_IDLE: begin
				if (!rxd) begin
					st_nxt.st = RX_START;
					st_nxt.cnt = bit_cycles >> 1;
					st_nxt.perr = 1'h0;
				end
			end
			RX_START: begin
				// A start bit shorter than half a bit is taken as noise
				if (tick) begin
					st_nxt.st = rxd ? RX_IDLE : RX_DATA;
					st_nxt.cnt = reload;
					st_nxt.nbit = 4'h0;
				end
			end
			RX_DATA: begin
				if (tick) begin
					st_nxt.cnt = reload;
					st_nxt.sh = {rxd, st_r.sh[7:1]};
					st_nxt.nbit = st_r.nbit + 1'h1;
					if (st_r.nbit == (cfg.len8 ? LAST_BIT_8 : LAST_BIT_7)) begin
						st_nxt.st = (cfg.par == PAR_NONE) ? RX_STOP : RX_PAR;
					end
				end
			end
			RX_PAR: begin
				if (tick) begin
					st_nxt.st = RX_STOP;
					st_nxt.cnt = reload;
					st_nxt.perr = (rxd != parity_bit(byte_in, cfg.len8, cfg.par));
				end
			end
			RX_STOP: begin
				// Only the first stop bit is checked, so a sender with two is accepted
				if (tick) begin
					st_nxt.st = RX_IDLE;
					st_nxt.evt = '{valid: 1'h1, perr: st_r.perr, ferr: !rxd, data: byte_in};
				end
			end
			default: st_nxt = RX_RESET;
		endcase
		if (restart) begin
			st_nxt = RX_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= RX_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign evt = st_r.evt;

endmodule

//--- hdl/serial_tx.sv
// Serial transmitter: start bit, data LSB first, optional parity, stop bits.
// Assumes cfg and bit_cycles only change together with a restart pulse.
`timescale 1ns/1ps
module serial_tx
	import serial_cfg_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             restart,
	input  serial_cfg_t           cfg,
	input  wire logic [CNT_W-1:0] bit_cycles,
	input  wire logic             start,
	input  wire logic [7:0]       data,
	output logic                  busy,
	output logic                  txd
);
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} tx_st_t;

	typedef struct packed {
		tx_st_t           st;
		logic [CNT_W-1:0] cnt;
		logic [3:0]       nbit;
		logic [7:0]       sh;
		logic             pbit;
		logic             line;
	} tx_state_t;

	localparam tx_state_t TX_RESET = '{st: TX_IDLE, cnt: '0, nbit: 4'h0, sh: 8'h00,
		pbit: 1'h0, line: 1'h1};

	tx_state_t        st_r;
	tx_state_t        st_nxt;
	logic             tick;
	logic [CNT_W-1:0] reload;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		tick = (st_r.cnt == '0);
		reload = bit_cycles - 1'h1;
		if (st_r.st != TX_IDLE && !tick) begin
			st_nxt.cnt = st_r.cnt - 1'h1;
		end
		unique case (st_r.st)
			TX_IDLE: begin
				if (start) begin
					st_nxt.st = TX_START;
					st_nxt.cnt = reload;
					st_nxt.sh = data;
					st_nxt.pbit = parity_bit(data, cfg.len8, cfg.par);
					st_nxt.nbit = 4'h0;
					st_nxt.line = 1'h0;
				end
			end
			TX_START, TX_DATA: begin
				if (tick) begin
					st_nxt.cnt = reload;
					st_nxt.line = st_r.sh[0];
					st_nxt.sh = st_r.sh >> 1;
					if (st_r.st == TX_DATA) begin
						st_nxt.nbit = st_r.nbit + 1'h1;
						if (st_r.nbit == (cfg.len8 ? LAST_BIT_8 : LAST_BIT_7)) begin
							st_nxt.nbit = 4'h0;
							st_nxt.st = (cfg.par == PAR_NONE) ? TX_STOP : TX_PAR;
							st_nxt.line = (cfg.par == PAR_NONE) ? 1'h1 : st_r.pbit;
						end
					end else begin
						st_nxt.st = TX_DATA;
					end
				end
			end
			TX_PAR: begin
				if (tick) begin
					st_nxt.st = TX_STOP;
					st_nxt.cnt = reload;
					st_nxt.line = 1'h1;
				end
			end
			TX_STOP: begin
				if (tick) begin
					st_nxt.cnt = reload;
					if (cfg.stop2 && st_r.nbit == 4'h0) begin
						st_nxt.nbit = 4'h1;
					end else begin
						st_nxt.st = TX_IDLE;
					end
				end
			end
			default: st_nxt = TX_RESET;
		endcase
		// A restart drops any frame in flight; the line returns to idle high
		if (restart) begin
			st_nxt = TX_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= TX_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = (st_r.st != TX_IDLE);
	assign txd  = st_r.line;

	////////////////////////////////////////////////////////////////////////////
	chk_tx_start_low: assert property (@(posedge core_clk) disable iff (sys_rst)
		start && !restart && st_r.st == TX_IDLE |=> !txd && st_r.cnt == $past(reload))
		else $error("start bit not low or bit period wrong");
	chk_tx_stop_high: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_r.st == TX_STOP |-> txd)
		else $error("stop bit not high");

endmodule

//--- include/serial_cfg_pkg.sv
// Shared constants, types and helpers for the serial port and its settings.
// Assumes one core clock; every module imports the whole package.
package serial_cfg_pkg;

	localparam int unsigned CLK_HZ_DEF = 250_000_000;
	localparam int unsigned CNT_W      = 20;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_RATE  = 8'h00;
	localparam logic [7:0] OFS_LEN   = 8'h04;
	localparam logic [7:0] OFS_PAR   = 8'h08;
	localparam logic [7:0] OFS_STOP  = 8'h0c;
	localparam logic [7:0] OFS_APPLY = 8'h10;
	localparam logic [7:0] OFS_FLOW  = 8'h14;
	localparam logic [7:0] OFS_STAT  = 8'h18;
	localparam logic [7:0] OFS_TXD   = 8'h1c;
	localparam logic [7:0] OFS_RXD   = 8'h20;
	localparam logic [7:0] OFS_ACT   = 8'h24;

	// Setting words as software writes and reads them, then last data bit indices
	localparam logic [31:0] BPS_300     = 32'h12c;
	localparam logic [31:0] BPS_600     = 32'h258;
	localparam logic [31:0] BPS_1200    = 32'h4b0;
	localparam logic [31:0] BPS_2400    = 32'h960;
	localparam logic [31:0] BPS_4800    = 32'h12c0;
	localparam logic [31:0] BPS_9600    = 32'h2580;
	localparam logic [31:0] LEN_7_W     = 32'h7;
	localparam logic [31:0] LEN_8_W     = 32'h8;
	localparam logic [31:0] STOP_1_W    = 32'h1;
	localparam logic [31:0] STOP_2_W    = 32'h2;
	localparam logic [31:0] CHAR_N_W    = 32'h4e;
	localparam logic [31:0] CHAR_E_W    = 32'h45;
	localparam logic [31:0] CHAR_O_W    = 32'h4f;
	localparam logic [31:0] FLOW_NONE_W = 32'h4e4f4e45;
	localparam logic [3:0]  LAST_BIT_7  = 4'h6;
	localparam logic [3:0]  LAST_BIT_8  = 4'h7;

	// Status bit positions
	localparam int ST_TX_BUSY  = 0;
	localparam int ST_RX_VALID = 1;
	localparam int ST_PAR_ERR  = 2;
	localparam int ST_FRM_ERR  = 3;
	localparam int ST_OVERRUN  = 4;
	localparam int ST_REJECT   = 5;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		RATE_300  = 3'b000,
		RATE_600  = 3'b001,
		RATE_1200 = 3'b010,
		RATE_2400 = 3'b011,
		RATE_4800 = 3'b100,
		RATE_9600 = 3'b101
	} rate_t;

	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_EVEN = 2'b01,
		PAR_ODD  = 2'b10
	} parity_t;

	typedef struct packed {
		rate_t   rate;
		logic    len8;
		parity_t par;
		logic    stop2;
	} serial_cfg_t;

	localparam serial_cfg_t CFG_RESET = '{rate: RATE_9600, len8: 1'h1, par: PAR_NONE,
		stop2: 1'h0};

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic       valid;
		logic       perr;
		logic       ferr;
		logic [7:0] data;
	} rx_evt_t;

	////////////////////////////////////////////////////////////////////////////
	// Parity bit over the data bits that the frame actually carries
	function automatic logic parity_bit(logic [7:0] d, logic len8, parity_t p);
		logic x;
		x = len8 ? ^d : ^d[6:0];
		return (p == PAR_ODD) ? ~x : x;
	endfunction

	// Returns {legal, code} for a bit rate written in bits per second
	function automatic logic [3:0] rate_code(logic [31:0] w);
		case (w)
			BPS_300:  return {1'h1, RATE_300};
			BPS_600:  return {1'h1, RATE_600};
			BPS_1200: return {1'h1, RATE_1200};
			BPS_2400: return {1'h1, RATE_2400};
			BPS_4800: return {1'h1, RATE_4800};
			BPS_9600: return {1'h1, RATE_9600};
			default:  return {1'h0, RATE_9600};
		endcase
	endfunction

	// Returns {legal, code} for a parity character
	function automatic logic [2:0] par_code(logic [31:0] w);
		case (w)
			CHAR_N_W: return {1'h1, PAR_NONE};
			CHAR_E_W: return {1'h1, PAR_EVEN};
			CHAR_O_W: return {1'h1, PAR_ODD};
			default:  return {1'h0, PAR_NONE};
		endcase
	endfunction

endpackage

//--- tb/remote_client.sv
// Remote client at the far end of the serial line.
// Assumes the bench sets cfg and n to match the port after each apply.
`timescale 1ns/1ps
module remote_client
	import serial_cfg_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       txd,
	input  serial_cfg_t     cfg,
	input  wire logic [9:0] n,
	output logic            rxd,
	output logic [8:0]      got
);
	initial rxd = 1'h1;
	initial got = 9'h0;
	always begin
		@(negedge txd);
		repeat (n / 2) @(posedge core_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (n) @(posedge core_clk);
			got[i] = txd;
		end
	end
	////////////////////////////////////////
	// frame build
	task automatic send(input logic [7:0] d);
		logic [11:0] f;
		logic        x;
		int          k;
		f = 12'hfff;
		x = (cfg.par == PAR_ODD);
		k = cfg.len8 ? 8 : 7;
		f[0] = 1'h0;
		for (int i = 0; i < k; i++) begin
			f[i + 1] = d[i];
			x ^= d[i];
		end
		if (cfg.par != PAR_NONE)
			f[k + 1] = x;
		// Trailing ones leave the line idle high
		for (int i = 0; i < 12; i++) begin
			rxd <= f[i];
			repeat (n) @(posedge core_clk);
		end
	endtask
endmodule

//--- tb/tb_top.sv
// Bench for the serial port: settings, apply, frames both ways.
// Assumes zero wait state APB and a shortened clock rate.
`timescale 1ns/1ps
module tb_top
	import serial_cfg_pkg::*;
;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic        e;
		logic [31:0] r;
	} row_t;
	localparam serial_cfg_t CFG_NEW = '{rate: RATE_4800, len8: 1'h0, par: PAR_EVEN,
		stop2: 1'h1};
	localparam row_t ROWS [19] = '{
		'{OFS_RATE, BPS_300, 1'h0, BPS_300},
		'{OFS_RATE, BPS_600, 1'h0, BPS_600},
		'{OFS_RATE, BPS_1200, 1'h0, BPS_1200},
		'{OFS_RATE, BPS_2400, 1'h0, BPS_2400},
		'{OFS_RATE, BPS_4800, 1'h0, BPS_4800},
		'{OFS_RATE, BPS_9600, 1'h0, BPS_9600},
		'{OFS_RATE, 32'h64, 1'h1, BPS_9600},
		'{OFS_LEN, LEN_7_W, 1'h0, LEN_7_W},
		'{OFS_LEN, 32'h9, 1'h1, LEN_7_W},
		'{OFS_LEN, LEN_8_W, 1'h0, LEN_8_W},
		'{OFS_PAR, CHAR_E_W, 1'h0, CHAR_E_W},
		'{OFS_PAR, CHAR_O_W, 1'h0, CHAR_O_W},
		'{OFS_PAR, 32'h58, 1'h1, CHAR_O_W},
		'{OFS_PAR, CHAR_N_W, 1'h0, CHAR_N_W},
		'{OFS_STOP, STOP_2_W, 1'h0, STOP_2_W},
		'{OFS_STOP, 32'h0, 1'h1, STOP_2_W},
		'{OFS_STOP, STOP_1_W, 1'h0, STOP_1_W},
		'{OFS_FLOW, 32'h0, 1'h0, FLOW_NONE_W},
		'{8'h28, 32'h1, 1'h1, 32'h0}
	};
	logic        core_clk = 1'h0;
	logic        sys_rst  = 1'h1;
	apb_req_t    req      = '0;
	serial_cfg_t rc_cfg   = CFG_RESET;
	logic [9:0]  rc_n     = 10'h00a;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        er;
	logic        txd;
	logic        rxd;
	logic [8:0]  got;
	serial_cfg_t active_cfg;
	int          n_fail;
	int          samples_checked;

	always #2 core_clk = ~core_clk;

	// Bit length 10 cycles at 9600, 20 at 4800
	serial_port_config_apply #(.CLK_HZ(96000)) serial_port_config_apply_i (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.apb_req    (req),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.rxd        (rxd),
		.txd        (txd),
		.active_cfg (active_cfg)
	);
	remote_client remote_client_i (
		.core_clk (core_clk),
		.txd      (txd),
		.cfg      (rc_cfg),
		.n        (rc_n),
		.rxd      (rxd),
		.got      (got)
	);
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
		@(posedge core_clk);
		req.penable <= 1'h1;
		do
			@(posedge core_clk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		req <= '0;
	endtask
	task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'h1, a, d);
		chk({31'h0, er}, {31'h0, e});
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(rd, x);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'h0;
		foreach (ROWS[i]) begin
			wrchk(ROWS[i].a, ROWS[i].d, ROWS[i].e);
			rdchk(ROWS[i].a, ROWS[i].r);
		end
		chk({25'h0, active_cfg}, {25'h0, CFG_RESET});
		$display("settings rows done");
		sys_rst <= 1'h1;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'h0;
		rdchk(OFS_RATE, BPS_9600);
		rdchk(OFS_LEN, LEN_8_W);
		rdchk(OFS_STOP, STOP_1_W);
		chk({31'h0, txd}, 32'h1);
		$display("reset values done");
		wrchk(OFS_TXD, 32'ha5, 1'h0);
		wrchk(OFS_TXD, 32'h5a, 1'h1);
		repeat (120) @(posedge core_clk);
		chk({23'h0, got}, 32'h1a5);
		wrchk(OFS_RATE, BPS_4800, 1'h0);
		wrchk(OFS_LEN, LEN_7_W, 1'h0);
		wrchk(OFS_PAR, CHAR_E_W, 1'h0);
		wrchk(OFS_STOP, STOP_2_W, 1'h0);
		chk({25'h0, active_cfg}, {25'h0, CFG_RESET});
		wrchk(OFS_APPLY, 32'h1, 1'h0);
		rdchk(OFS_ACT, {25'h0, CFG_NEW});
		chk({25'h0, active_cfg}, {25'h0, CFG_NEW});
		rc_cfg = CFG_NEW;
		rc_n = 10'h014;
		wrchk(OFS_TXD, 32'hd3, 1'h0);
		repeat (240) @(posedge core_clk);
		chk({23'h0, got}, 32'h153);
		remote_client_i.send(8'h2c);
		rdchk(OFS_RXD, 32'h2c);
		$display("apply and frames done");
		// Odd parity applied while the client still sends even: a parity error must show
		wrchk(OFS_PAR, CHAR_O_W, 1'h0);
		wrchk(OFS_APPLY, 32'h1, 1'h0);
		rdchk(OFS_PAR, CHAR_O_W);
		remote_client_i.send(8'h2c);
		rdchk(OFS_STAT, (32'h1 << ST_RX_VALID) | (32'h1 << ST_PAR_ERR)
			| (32'h1 << ST_REJECT));
		rdchk(OFS_RXD, 32'h2c);
		rc_cfg.par = PAR_ODD;
		wrchk(OFS_TXD, 32'h5a, 1'h0);
		repeat (240) @(posedge core_clk);
		chk({23'h0, got}, 32'h1da);
		$display("odd parity done");
		final_report();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		final_report();
	end
endmodule
